// file: verilog/occ_regs.svh
// register offsets, field positions, reset values and delay figures of one output channel slice
// assumes byte-wide registers on the device configuration port, addressed by register number
`ifndef OCC_REGS_SVH
`define OCC_REGS_SVH

`define OCC_ADDR_PHASE_STRENGTH 8'h43
`define OCC_ADDR_DELAY_CTRL 8'h44
`define OCC_ADDR_DRIVER_SEL 8'h45
`define OCC_ADDR_TERM_MODE 8'h47
`define OCC_ADDR_NEXT_DIV_UPPER 8'h48
`define OCC_ADDR_DIV_LAST_BYTE 8'h42
`define OCC_ADDR_NEXT_DIV_LAST_BYTE 8'h4A

`define OCC_RESET_BYTE 8'h00

`define OCC_PHASE_MSB 7
`define OCC_PHASE_LSB 6
`define OCC_STRENGTH_MSB 2
`define OCC_COARSE_MSB 5
`define OCC_FINE_MSB 7
`define OCC_FINE_LSB 6
`define OCC_SUPPLY_MSB 4
`define OCC_SUPPLY_LSB 3
`define OCC_DRIVER_MSB 2
`define OCC_DIV_HI_MSB 7
`define OCC_DIV_HI_LSB 6
`define OCC_FINE_EXT_BIT 4
`define OCC_MODE_MSB 3
`define OCC_NEXT_DIV_MSB 3

`define OCC_COARSE_MAX 63
`define OCC_FINE_STEP_PS 30
`define OCC_FINE_EXT_MAX 3'h4

`endif

// file: verilog/occ_pkg.sv
// types shared by the output channel slice: supply, driver standard and pin mode codes
// assumes occ_regs.svh supplies offsets and field positions
package occ_pkg;

    typedef enum logic [1:0] {
        OCC_VDD_1V8 = 2'h0,
        OCC_VDD_2V5 = 2'h1,
        OCC_VDD_3V3 = 2'h2
    } occ_supply_t;

    typedef enum logic [2:0] {
        OCC_DRV_LVDS = 3'h0,
        OCC_DRV_LVPECL_CM = 3'h1,
        OCC_DRV_CML = 3'h2,
        OCC_DRV_HCSL = 3'h3,
        OCC_DRV_LVDS_BOOST = 3'h4,
        OCC_DRV_LVPECL_NOCM = 3'h5
    } occ_driver_t;

    typedef enum logic [3:0] {
        OCC_MODE_DIFF_EXT = 4'h0,
        OCC_MODE_DIFF_PDN = 4'h1,
        OCC_MODE_DIFF_PUP = 4'h2,
        OCC_MODE_SE_POS = 4'h4,
        OCC_MODE_SE_NEG = 4'h8,
        OCC_MODE_SE_BOTH = 4'hC
    } occ_mode_t;

    typedef enum logic [1:0] {
        OCC_PH_STRAIGHT = 2'h0,
        OCC_PH_TRUE_BOTH = 2'h1,
        OCC_PH_COMP_BOTH = 2'h2,
        OCC_PH_SWAP = 2'h3
    } occ_phase_t;

endpackage

// file: verilog/occ_delay_drv.sv
// coarse delay line and pin driver steering for one output channel
// assumes the channel clock arrives as a level sampled on CLK, one CLK period per delay step
`timescale 1ns/100ps
`include "occ_regs.svh"

module occ_delay_drv #(
    parameter int DEPTH = `OCC_COARSE_MAX + 1
) (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // channel clock and settings
    input wire logic sig_in,
    input wire logic [5:0] coarse_code,
    input wire logic [1:0] phase_sel,
    input wire logic [3:0] mode,
    // pins
    output logic positive_pin,
    output logic negative_pin,
    output logic positive_oe_n,
    output logic negative_oe_n
);

    logic [DEPTH-1:0] line_reg;
    logic pos_reg;
    logic neg_reg;
    logic pos_oe_n_reg;
    logic neg_oe_n_reg;

    wire logic true_clock;
    wire logic complement_clock;
    wire logic positive_driver_source;
    wire logic negative_driver_source;
    wire logic single_ended;
    wire logic pos_next;
    wire logic neg_next;
    wire logic pos_oe_n_next;
    wire logic neg_oe_n_next;

    // one flop per step; the tap picks code periods on top of the fixed two-cycle path
    always_ff @(posedge clk) begin
        if (srst) begin
            line_reg[0] <= 1'b0;
        end else begin
            line_reg[0] <= sig_in;
        end
    end

    genvar gi;
    generate
        for (gi = 1; gi < DEPTH; gi++) begin : g_line
            always_ff @(posedge clk) begin
                if (srst) begin
                    line_reg[gi] <= 1'b0;
                end else begin
                    line_reg[gi] <= line_reg[gi-1];
                end
            end
        end
    endgenerate

    assign true_clock = line_reg[coarse_code];
    assign complement_clock = ~true_clock;

    // phase routing only matters for the single-ended drivers
    assign positive_driver_source = phase_sel[1] ? complement_clock : true_clock;
    assign negative_driver_source = (phase_sel == occ_pkg::OCC_PH_STRAIGHT) ? complement_clock :
                                    (phase_sel == occ_pkg::OCC_PH_TRUE_BOTH) ? true_clock :
                                    (phase_sel == occ_pkg::OCC_PH_COMP_BOTH) ? complement_clock :
                                    true_clock;

    assign single_ended = mode[3] | mode[2];
    assign pos_next = single_ended ? positive_driver_source : true_clock;
    assign neg_next = single_ended ? negative_driver_source : complement_clock;

    // unlisted patterns float both pins rather than guess a termination
    assign pos_oe_n_next = !((mode == occ_pkg::OCC_MODE_DIFF_EXT) ||
                             (mode == occ_pkg::OCC_MODE_DIFF_PUP) ||
                             (mode == occ_pkg::OCC_MODE_DIFF_PDN) ||
                             (mode == occ_pkg::OCC_MODE_SE_POS) ||
                             (mode == occ_pkg::OCC_MODE_SE_BOTH));
    assign neg_oe_n_next = !((mode == occ_pkg::OCC_MODE_DIFF_EXT) ||
                             (mode == occ_pkg::OCC_MODE_DIFF_PUP) ||
                             (mode == occ_pkg::OCC_MODE_DIFF_PDN) ||
                             (mode == occ_pkg::OCC_MODE_SE_NEG) ||
                             (mode == occ_pkg::OCC_MODE_SE_BOTH));

    always_ff @(posedge clk) begin
        if (srst) begin
            pos_reg <= 1'b0;
            neg_reg <= 1'b0;
            pos_oe_n_reg <= 1'b1;
            neg_oe_n_reg <= 1'b1;
        end else begin
            pos_reg <= pos_next;
            neg_reg <= neg_next;
            pos_oe_n_reg <= pos_oe_n_next;
            neg_oe_n_reg <= neg_oe_n_next;
        end
    end

    assign positive_pin = pos_reg;
    assign negative_pin = neg_reg;
    assign positive_oe_n = pos_oe_n_reg;
    assign negative_oe_n = neg_oe_n_reg;

    a_zero_skew_path: assert property (@(posedge clk) disable iff (srst)
        (coarse_code == 6'h00 && $past(coarse_code) == 6'h00 && !$past(srst))
        |-> (true_clock == $past(sig_in)))
        else $error("zero skew tap is not one cycle behind the input");

    a_phase_swap: assert property (@(posedge clk) disable iff (srst)
        (single_ended && phase_sel == occ_pkg::OCC_PH_SWAP)
        |=> (positive_pin == !$past(true_clock) && negative_pin == $past(true_clock)))
        else $error("swapped phase routing wrong");

    a_diff_pins: assert property (@(posedge clk) disable iff (srst)
        (mode == occ_pkg::OCC_MODE_DIFF_PUP) |=> (!positive_oe_n && !negative_oe_n &&
        positive_pin != negative_pin))
        else $error("differential mode not complementary on both pins");

    a_se_neg_only: assert property (@(posedge clk) disable iff (srst)
        (mode == occ_pkg::OCC_MODE_SE_NEG) |=> (positive_oe_n && !negative_oe_n))
        else $error("negative-only mode drives the wrong pin");

    c_se_both: cover property (@(posedge clk) disable iff (srst)
        mode == occ_pkg::OCC_MODE_SE_BOTH ##1 !positive_oe_n && !negative_oe_n);
    c_max_skew: cover property (@(posedge clk) disable iff (srst)
        coarse_code == 6'h3F && $rose(true_clock));

endmodule

// file: verilog/occ_channel_regs.sv
// configuration registers of one clock output channel and the channel's pin driver
// assumes a byte-wide, single-cycle register port driven by the configuration port logic
//
// What this block does
// - phase code steers true, complement, both or swapped onto the single-ended pins
// - six-bit coarse code delays the output by that many oscillator periods
// - two-bit fine code adds zero to three thirty-picosecond steps
// - extended three-bit fine code gives zero to four thirty-picosecond steps
// - supply field bits four to three: 1.8, 2.5 or 3.3 volts
// - driver field selects LVDS, boosted LVDS, CML, HCSL or LVPECL variants
// - mode zero external termination; bit one pull-up, bit zero pull-down, differential
// - mode 0100 positive pin, 1000 negative pin, 1100 both pins single-ended
// - termination register bits seven to six carry divider bits thirty-three and thirty-two
// - register 48h bits three to zero carry next channel divider bits nineteen to sixteen
// - every field is read-write and resets to zero
`timescale 1ns/100ps
`include "occ_regs.svh"

module occ_channel_regs #(
    parameter int DELAY_DEPTH = `OCC_COARSE_MAX + 1
) (
    // clock and reset
    input wire logic CLK,
    input wire logic SRST,
    // register port
    input wire logic [7:0] REG_ADDR,
    input wire logic REG_WR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_RD,
    output logic [7:0] REG_RDATA,
    // channel clock in and pins out
    input wire logic SIG_TRUE,
    output logic POSITIVE_PIN,
    output logic NEGATIVE_PIN,
    output logic POSITIVE_OE_N,
    output logic NEGATIVE_OE_N,
    // settings to the analog driver and divider
    output logic [5:0] OUTPUT_SKEW_COARSE,
    output logic [2:0] FINE_STEPS,
    output logic [1:0] OUTPUT_SUPPLY_SELECT,
    output logic SUPPLY_INVALID,
    output logic [2:0] DRIVER_STANDARD_SELECT,
    output logic DRIVER_INVALID,
    output logic [2:0] SE_STRENGTH,
    output logic [3:0] TERM_MODE,
    output logic [1:0] OUTPUT_DIVIDE_RATIO_HI,
    output logic [3:0] NEXT_DIVIDE_RATIO_HI
);

    logic [7:0] phase_strength_reg;
    logic [7:0] output_delay_control_reg;
    logic [7:0] output_driver_select_reg;
    logic [7:0] output_termination_mode_reg;
    logic [7:0] next_divider_upper_byte_reg;
    logic [7:0] rdata_reg;
    logic [2:0] fine_reg;
    logic supply_bad_reg;
    logic driver_bad_reg;
    logic [1:0] div_hi_reg;
    logic [3:0] next_div_hi_reg;

    function automatic logic hit(input logic [7:0] addr, input logic [7:0] target);
        hit = (addr == target);
    endfunction

    // the fine code saturates at four steps; codes five to seven ask for more than exists
    function automatic logic [2:0] fine_clamp(input logic [2:0] code);
        fine_clamp = (code > `OCC_FINE_EXT_MAX) ? `OCC_FINE_EXT_MAX : code;
    endfunction

    wire logic wr_phase = REG_WR && hit(REG_ADDR, `OCC_ADDR_PHASE_STRENGTH);
    wire logic wr_delay = REG_WR && hit(REG_ADDR, `OCC_ADDR_DELAY_CTRL);
    wire logic wr_driver = REG_WR && hit(REG_ADDR, `OCC_ADDR_DRIVER_SEL);
    wire logic wr_term = REG_WR && hit(REG_ADDR, `OCC_ADDR_TERM_MODE);
    wire logic wr_next = REG_WR && hit(REG_ADDR, `OCC_ADDR_NEXT_DIV_UPPER);
    wire logic wr_div_last = REG_WR && hit(REG_ADDR, `OCC_ADDR_DIV_LAST_BYTE);
    wire logic wr_next_last = REG_WR && hit(REG_ADDR, `OCC_ADDR_NEXT_DIV_LAST_BYTE);

    // reserved bits are never stored, so they read back as zero
    wire logic [7:0] phase_next = wr_phase ? (REG_WDATA & 8'hC7) : phase_strength_reg;
    wire logic [7:0] delay_next = wr_delay ? REG_WDATA : output_delay_control_reg;
    wire logic [7:0] driver_next = wr_driver ? (REG_WDATA & 8'h1F) :
                                   output_driver_select_reg;
    wire logic [7:0] term_next = wr_term ? (REG_WDATA & 8'hDF) :
                                 output_termination_mode_reg;
    wire logic [7:0] nextdiv_next = wr_next ? (REG_WDATA & 8'h0F) :
                                    next_divider_upper_byte_reg;

    wire logic [2:0] fine_next = fine_clamp({term_next[`OCC_FINE_EXT_BIT],
                                 delay_next[`OCC_FINE_MSB:`OCC_FINE_LSB]});
    wire logic [1:0] supply_field = driver_next[`OCC_SUPPLY_MSB:`OCC_SUPPLY_LSB];
    wire logic [2:0] driver_field = driver_next[`OCC_DRIVER_MSB:0];
    wire logic supply_bad_next = (supply_field != occ_pkg::OCC_VDD_1V8) &&
                                 (supply_field != occ_pkg::OCC_VDD_2V5) &&
                                 (supply_field != occ_pkg::OCC_VDD_3V3);
    wire logic driver_bad_next = driver_field[2] && driver_field[1];

    // a staged upper divider part reaches the divider only with its last byte
    wire logic [1:0] div_hi_next = wr_div_last ?
                                   output_termination_mode_reg[`OCC_DIV_HI_MSB:`OCC_DIV_HI_LSB] :
                                   div_hi_reg;
    wire logic [3:0] next_div_hi_next = wr_next_last ?
                                        next_divider_upper_byte_reg[`OCC_NEXT_DIV_MSB:0] :
                                        next_div_hi_reg;

    wire logic [7:0] rd_mux = hit(REG_ADDR, `OCC_ADDR_PHASE_STRENGTH) ? phase_strength_reg :
                              hit(REG_ADDR, `OCC_ADDR_DELAY_CTRL) ? output_delay_control_reg :
                              hit(REG_ADDR, `OCC_ADDR_DRIVER_SEL) ? output_driver_select_reg :
                              hit(REG_ADDR, `OCC_ADDR_TERM_MODE) ? output_termination_mode_reg :
                              hit(REG_ADDR, `OCC_ADDR_NEXT_DIV_UPPER) ?
                              next_divider_upper_byte_reg : `OCC_RESET_BYTE;
    wire logic [7:0] rdata_next = REG_RD ? rd_mux : rdata_reg;

    always_ff @(posedge CLK) begin
        if (SRST) begin
            phase_strength_reg <= `OCC_RESET_BYTE;
            output_delay_control_reg <= `OCC_RESET_BYTE;
            output_driver_select_reg <= `OCC_RESET_BYTE;
            output_termination_mode_reg <= `OCC_RESET_BYTE;
            next_divider_upper_byte_reg <= `OCC_RESET_BYTE;
            rdata_reg <= `OCC_RESET_BYTE;
            fine_reg <= 3'h0;
            supply_bad_reg <= 1'b0;
            driver_bad_reg <= 1'b0;
            div_hi_reg <= 2'h0;
            next_div_hi_reg <= 4'h0;
        end else begin
            phase_strength_reg <= phase_next;
            output_delay_control_reg <= delay_next;
            output_driver_select_reg <= driver_next;
            output_termination_mode_reg <= term_next;
            next_divider_upper_byte_reg <= nextdiv_next;
            rdata_reg <= rdata_next;
            fine_reg <= fine_next;
            supply_bad_reg <= supply_bad_next;
            driver_bad_reg <= driver_bad_next;
            div_hi_reg <= div_hi_next;
            next_div_hi_reg <= next_div_hi_next;
        end
    end

    assign REG_RDATA = rdata_reg;
    assign OUTPUT_SKEW_COARSE = output_delay_control_reg[`OCC_COARSE_MSB:0];
    assign FINE_STEPS = fine_reg;
    assign OUTPUT_SUPPLY_SELECT = output_driver_select_reg[`OCC_SUPPLY_MSB:`OCC_SUPPLY_LSB];
    assign SUPPLY_INVALID = supply_bad_reg;
    assign DRIVER_STANDARD_SELECT = output_driver_select_reg[`OCC_DRIVER_MSB:0];
    assign DRIVER_INVALID = driver_bad_reg;
    // strength passes through as written; seven is the setting software is expected to use
    assign SE_STRENGTH = phase_strength_reg[`OCC_STRENGTH_MSB:0];
    assign TERM_MODE = output_termination_mode_reg[`OCC_MODE_MSB:0];
    assign OUTPUT_DIVIDE_RATIO_HI = div_hi_reg;
    assign NEXT_DIVIDE_RATIO_HI = next_div_hi_reg;

    occ_delay_drv #(
        .DEPTH(DELAY_DEPTH)
    ) u_drv (
        .clk(CLK),
        .srst(SRST),
        .sig_in(SIG_TRUE),
        .coarse_code(output_delay_control_reg[`OCC_COARSE_MSB:0]),
        .phase_sel(phase_strength_reg[`OCC_PHASE_MSB:`OCC_PHASE_LSB]),
        .mode(output_termination_mode_reg[`OCC_MODE_MSB:0]),
        .positive_pin(POSITIVE_PIN),
        .negative_pin(NEGATIVE_PIN),
        .positive_oe_n(POSITIVE_OE_N),
        .negative_oe_n(NEGATIVE_OE_N)
    );

    a_reset_zero: assert property (@(posedge CLK)
        SRST |=> (OUTPUT_SKEW_COARSE == 6'h00 && TERM_MODE == 4'h0 && FINE_STEPS == 3'h0))
        else $error("fields not zero after reset");

    a_coarse_write: assert property (@(posedge CLK) disable iff (SRST)
        wr_delay |=> OUTPUT_SKEW_COARSE == $past(REG_WDATA[5:0]))
        else $error("coarse skew not taken from write");

    a_fine_limit: assert property (@(posedge CLK) disable iff (SRST)
        (wr_delay && REG_WDATA[7:6] == 2'h3 && output_termination_mode_reg[4])
        |=> FINE_STEPS == 3'h4)
        else $error("extended fine code not clamped to four");

    a_readback: assert property (@(posedge CLK) disable iff (SRST)
        wr_next ##1 (REG_RD && REG_ADDR == 8'h48) |=> REG_RDATA == {4'h0, $past(REG_WDATA[3:0], 2)})
        else $error("register 48h read back wrong");

    a_div_hold: assert property (@(posedge CLK) disable iff (SRST)
        (!$past(wr_div_last) && !$past(SRST)) |-> $stable(OUTPUT_DIVIDE_RATIO_HI))
        else $error("divider upper bits moved without last byte write");

    // a reset edge may clear the applied bits, so the cycle after reset is left out
    a_next_hold: assert property (@(posedge CLK) disable iff (SRST)
        (!$past(wr_next_last) && !$past(SRST)) |-> $stable(NEXT_DIVIDE_RATIO_HI))
        else $error("next channel divider bits moved without last byte write");

    a_rdata_hold: assert property (@(posedge CLK) disable iff (SRST)
        (!$past(REG_RD) && !$past(SRST)) |-> $stable(REG_RDATA))
        else $error("read data changed without a read");

    a_fine_short: assert property (@(posedge CLK) disable iff (SRST)
        (wr_delay && !output_termination_mode_reg[`OCC_FINE_EXT_BIT]) |=>
        FINE_STEPS == {1'b0, $past(REG_WDATA[7:6])})
        else $error("two-bit fine code not passed through");

    a_next_apply: assert property (@(posedge CLK) disable iff (SRST)
        wr_next_last |=> NEXT_DIVIDE_RATIO_HI == $past(next_divider_upper_byte_reg[3:0]))
        else $error("next channel divider bits not applied");

    a_driver_flag: assert property (@(posedge CLK) disable iff (SRST)
        wr_driver |=> DRIVER_INVALID == ($past(REG_WDATA[2:1]) == 2'h3))
        else $error("driver code validity wrong");

    a_supply_flag: assert property (@(posedge CLK) disable iff (SRST)
        wr_driver |=> SUPPLY_INVALID == ($past(REG_WDATA[4:3]) == 2'h3))
        else $error("supply code validity wrong");

    c_div_apply: cover property (@(posedge CLK) disable iff (SRST)
        wr_term ##[1:4] wr_div_last ##1 OUTPUT_DIVIDE_RATIO_HI != 2'h0);
    c_fine_ext: cover property (@(posedge CLK) disable iff (SRST) FINE_STEPS == 3'h4);
    c_strength7: cover property (@(posedge CLK) disable iff (SRST) SE_STRENGTH == 3'h7);

endmodule

// file: tb/tb_top.sv
// self-checking bench for the output channel configuration slice and its pin driver
// assumes occ_channel_regs with default delay depth, byte register port, 100 MHz clock
`timescale 1ns/100ps

module tb_top;
    logic clk;
    logic srst;
    logic [7:0] reg_addr;
    logic reg_wr;
    logic [7:0] reg_wdata;
    logic reg_rd;
    logic [7:0] reg_rdata;
    logic sig_true = 1'b0;
    logic pos_pin, neg_pin, pos_oe_n, neg_oe_n;
    logic [5:0] coarse;
    logic [2:0] fine, drv, se_str;
    logic [1:0] supply, div_hi;
    logic sup_inv, drv_inv;
    logic [3:0] term, nx_hi;
    int fails = 0;
    int compares = 0;
    logic [31:0] st = 32'hEF116696;
    logic [7:0] q[$];
    logic rd_pend = 1'b0;
    logic [69:0] hist = '0;
    logic [7:0] r43 = 8'h00, r44 = 8'h00, r45 = 8'h00, r47 = 8'h00, r48 = 8'h00;
    logic [1:0] div_app = 2'h0;
    logic [3:0] nx_app = 4'h0;
    logic [7:0] ad[8] = '{8'h43, 8'h44, 8'h45, 8'h47, 8'h48, 8'h42, 8'h46, 8'h4A};
    logic [3:0] modes[7] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8, 4'hC, 4'h3};
    logic [5:0] cs[4] = '{6'h00, 6'h01, 6'h11, 6'h3F};

    occ_channel_regs dut (.CLK(clk), .SRST(srst), .REG_ADDR(reg_addr), .REG_WR(reg_wr),
        .REG_WDATA(reg_wdata), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .SIG_TRUE(sig_true),
        .POSITIVE_PIN(pos_pin), .NEGATIVE_PIN(neg_pin), .POSITIVE_OE_N(pos_oe_n),
        .NEGATIVE_OE_N(neg_oe_n), .OUTPUT_SKEW_COARSE(coarse), .FINE_STEPS(fine),
        .OUTPUT_SUPPLY_SELECT(supply), .SUPPLY_INVALID(sup_inv),
        .DRIVER_STANDARD_SELECT(drv), .DRIVER_INVALID(drv_inv), .SE_STRENGTH(se_str),
        .TERM_MODE(term), .OUTPUT_DIVIDE_RATIO_HI(div_hi), .NEXT_DIVIDE_RATIO_HI(nx_hi));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    function automatic logic [31:0] xs();
        st = st ^ (st << 13);
        st = st ^ (st >> 17);
        st = st ^ (st << 5);
        return st;
    endfunction

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // channel clock is random every cycle so a wrong delay tap cannot match by luck
    always @(negedge clk) sig_true <= 1'(xs() & 32'h1);
    always @(posedge clk) hist <= {hist[68:0], sig_true};
    always @(posedge clk) rd_pend <= reg_rd & ~srst;

    // read data has no valid strobe: it is due one cycle after each taken read
    always @(negedge clk) begin
        if (rd_pend) begin
            chk(reg_rdata, q.pop_front());
        end
    end

    task automatic op(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
        reg_wr = w;
        reg_rd = r;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clk);
    endtask

    task automatic cyc(input int n);
        repeat (n) op(1'b0, 1'b0, 8'h00, 8'h00);
    endtask

    function automatic logic [7:0] val(input logic [7:0] a);
        case (a)
            8'h43: return r43;
            8'h44: return r44;
            8'h45: return r45;
            8'h47: return r47;
            8'h48: return r48;
            default: return 8'h00;
        endcase
    endfunction

    task automatic chk_fields();
        logic [2:0] f;
        f = {r47[4], r44[7:6]};
        if (f > 3'h4)
            f = 3'h4;
        chk({2'h0, coarse}, {2'h0, r44[5:0]});
        chk({5'h0, fine}, {5'h0, f});
        chk({6'h0, supply}, {6'h0, r45[4:3]});
        chk({7'h0, sup_inv}, {7'h0, r45[4:3] == 2'h3});
        chk({5'h0, drv}, {5'h0, r45[2:0]});
        chk({7'h0, drv_inv}, {7'h0, r45[2:1] == 2'h3});
        chk({5'h0, se_str}, {5'h0, r43[2:0]});
        chk({4'h0, term}, {4'h0, r47[3:0]});
        chk({6'h0, div_hi}, {6'h0, div_app});
        chk({4'h0, nx_hi}, {4'h0, nx_app});
    endtask

    task automatic shadow(input logic [7:0] a, input logic [7:0] d);
        case (a)
            8'h43: r43 = d & 8'hC7;
            8'h44: r44 = d;
            8'h45: r45 = d & 8'h1F;
            8'h47: r47 = d & 8'hDF;
            8'h48: r48 = d & 8'h0F;
            8'h42: div_app = r47[7:6];
            8'h4A: nx_app = r48[3:0];
            default: ;
        endcase
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        op(1'b1, 1'b0, a, d);
        shadow(a, d);
        chk_fields();
    endtask

    task automatic rd(input logic [7:0] a);
        logic [31:0] v;
        v = xs();
        q.push_back(val(a));
        op(1'b0, 1'b1, a, v[7:0]);
    endtask

    initial begin
        #(20000 * 10);
        fails++;
        print_verdict();
    end

    initial begin
        logic [31:0] v;
        logic [3:0] m;
        logic [1:0] p;
        logic [5:0] c;
        logic t, ep, en, pe, ne;
        srst = 1'b1;
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_wdata = 8'h00;
        reg_rd = 1'b0;
        repeat (4) @(negedge clk);
        chk({6'h0, pos_oe_n, neg_oe_n}, 8'h03);
        chk({6'h0, pos_pin, neg_pin}, 8'h00);
        repeat (4) @(negedge clk);
        srst = 1'b0;
        chk_fields();
        for (int k = 0; k < 8; k++) rd(ad[k]);
        $display("test reset values done");
        for (int k = 0; k < 40; k++) begin
            v = xs();
            wr(ad[v[10:8]], v[7:0]);
            rd(ad[v[10:8]]);
        end
        // a read in the same cycle as a write must still see the old contents
        v = xs();
        q.push_back(r44);
        op(1'b1, 1'b1, 8'h44, v[7:0]);
        shadow(8'h44, v[7:0]);
        chk_fields();
        rd(8'h44);
        $display("test register access done");
        for (int i = 0; i < 8; i++) wr(8'h45, {3'h0, i[1:0], i[2:0]});
        for (int i = 0; i < 8; i++) begin
            wr(8'h47, {3'h0, i[2], 4'h0});
            wr(8'h44, {i[1:0], 6'h2A});
        end
        $display("test field codes done");
        wr(8'h47, 8'hC0);
        wr(8'h48, 8'h0B);
        wr(8'h42, 8'h00);
        wr(8'h47, 8'h40);
        wr(8'h4A, 8'h00);
        wr(8'h42, 8'h00);
        $display("test divider staging done");
        for (int i = 0; i < 28; i++) begin
            m = modes[i / 4];
            p = i[1:0];
            c = cs[(i + i / 4) % 4];
            wr(8'h43, {p, 3'h0, 3'h7});
            wr(8'h44, {2'h0, c});
            wr(8'h47, {4'h0, m});
            cyc(c + 6);
            for (int j = 0; j < 8; j++) begin
                t = hist[c + 1];
                pe = (m inside {4'h0, 4'h1, 4'h2, 4'h4, 4'hC});
                ne = (m inside {4'h0, 4'h1, 4'h2, 4'h8, 4'hC});
                case (p)
                    2'h0: {ep, en} = {t, ~t};
                    2'h1: {ep, en} = {t, t};
                    2'h2: {ep, en} = {~t, ~t};
                    default: {ep, en} = {~t, t};
                endcase
                if (m inside {4'h0, 4'h1, 4'h2})
                    {ep, en} = {t, ~t};
                chk({6'h0, pos_oe_n, neg_oe_n}, {6'h0, ~pe, ~ne});
                if (pe)
                    chk({7'h0, pos_pin}, {7'h0, ep});
                if (ne)
                    chk({7'h0, neg_pin}, {7'h0, en});
                cyc(1);
            end
        end
        $display("test pin modes and delay done");
        cyc(2);
        print_verdict();
    end
endmodule
